// ===== hw/reset_cause_pkg.sv
// Constants, field layouts and carrier types for the reset-cause and brown-out control block.
package reset_cause_pkg;

    // Register geometry and bus decode.
    localparam int unsigned REG_W                = 8;
    localparam int unsigned BUS_DATA_W           = 32;
    localparam int unsigned BUS_ADDR_W           = 4;
    localparam logic [3:0]  BROWNOUT_CONTROL_OFS = 4'h0;
    localparam logic [3:0]  RESET_CAUSE_OFS      = 4'h4;

    // Brown-out control register fields.
    localparam int unsigned SOFTWARE_BROWNOUT_ENABLE_BIT           = 7;
    localparam int unsigned RESERVED_BIT         = 6;
    localparam int unsigned READY_BIT            = 0;

    // Reset-cause register fields.
    localparam int unsigned STACK_OVERFLOW_FLAG_BIT           = 7;
    localparam int unsigned STACK_UNDERFLOW_FLAG_BIT           = 6;
    localparam int unsigned WDT_BIT              = 4;
    localparam int unsigned PIN_BIT              = 3;
    localparam int unsigned RI_BIT               = 2;
    localparam int unsigned POR_BIT              = 1;
    localparam int unsigned BOR_BIT              = 0;

    // Reset values and masks of the reset-cause register.
    localparam logic [7:0]  CAUSE_POR_VALUE      = 8'h1C;
    localparam logic [7:0]  CAUSE_BOR_SET        = 8'h1C;
    localparam logic [7:0]  CAUSE_BOR_KEEP       = 8'h02;
    localparam logic [7:0]  CAUSE_WRITE_MASK     = 8'hDF;

    // Reset values of the brown-out control register.
    localparam logic        SOFTWARE_BROWNOUT_ENABLE_RESET         = 1'b1;
    localparam logic        RESERVED_RESET       = 1'b0;

    // Brown-out configuration field encodings.
    localparam logic [1:0]  CFG_ALWAYS_OFF       = 2'h0;
    localparam logic [1:0]  CFG_SOFTWARE         = 2'h1;

    // Unmapped reads return this value.
    localparam logic [31:0] UNMAPPED_READ        = 32'h0000_0000;

    // Same-clock reset requests from the core.
    typedef struct packed {
        logic stack_overflow;
        logic stack_underflow;
        logic watchdog;
        logic reset_instruction;
    } reset_event_t;

    // Bus slave handshake states.
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h1,
        BUS_ACK  = 2'h2
    } bus_state_t;

endpackage : reset_cause_pkg

// ===== hw/level_sync.sv
// Two flip-flop synchroniser for asynchronous level inputs.
`timescale 1ns/10ps
module level_sync
    import reset_cause_pkg::*;
#(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    // Asynchronous input and its expected resting level.
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] idle_value,
    // Synchronised output.
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    // The first stage feeds only the second stage, which limits metastability spread.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

    // The idle value is only documentation of the expected resting level for users.
    logic unused_idle;
    assign unused_idle = ^idle_value;

endmodule : level_sync

// ===== hw/reset_cause_control.sv
// Brown-out control and reset-cause flag registers behind an Avalon-MM slave.
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/10ps

// Overview of operation
// - Mode 01: software bit enables brown-out detection.
// - Other modes: software bit stored, ignored.
// - Software enable bit 7, set by power-on/brown-out.
// - Bit 0 read-only, shows brown-out circuit active.
// - Bits 5-1 read zero; bit 6 reserved.
// - Only the flag of the actual cause changes; brown-out also reloads bits 7-2.
// - Hardware restores flags to inactive only on power-on and brown-out.
// - Software may force flags active, no reset.
// - Stack overflow flag bit 7, hardware sets.
// - Stack underflow flag bit 6, hardware sets.
// - Watchdog flag bit 4, cleared on watchdog reset.
// - Pin flag bit 3, cleared on pin reset.
// - Instruction flag bit 2, cleared on reset instruction.
// - Power-on flag bit 1 reads 0 after power-on.
// - Brown-out flag bit 0 reads 0 after brown-out.
// - Brown-out reset is OR of both detectors.
module reset_cause_control
    import reset_cause_pkg::*;
(
    // Clock and power-on reset.
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    // Avalon-MM slave.
    input  wire logic [BUS_ADDR_W-1:0] avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [BUS_DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [BUS_DATA_W-1:0] avs_readdata,
    output logic                       avs_waitrequest,
    // Static configuration word fields.
    input  wire logic [1:0]            brownout_config_mode,
    input  wire logic                  low_power_brownout_enable,
    input  wire logic                  external_reset_pin_enable,
    // Asynchronous analog and pin inputs.
    input  wire logic                  brownout_detector,
    input  wire logic                  low_power_brownout_detector,
    input  wire logic                  brownout_ready_raw,
    input  wire logic                  external_reset_pin_n,
    // Same-clock reset requests from the core.
    input  wire reset_event_t          reset_events,
    // Outputs to the power control block.
    output logic                       brownout_detect_enable,
    output logic                       brownout_reset
);

    // Synchronised copies of the asynchronous inputs.
    logic [3:0] async_raw;
    logic [3:0] async_sync;
    logic       bod_s;
    logic       lp_bod_s;
    logic       ready_s;
    logic       pin_low_s;

    // Register state.
    logic       software_brownout_enable_r;
    logic       reserved_r;
    logic [7:0] cause_r;
    logic [7:0] cause_nxt;
    bus_state_t bus_state_r;

    // Decoded bus strobes.
    logic       bus_req;
    logic       wr_take;
    logic       hit_brownout_control_wr;
    logic       hit_cause_wr;
    logic       low_lane;
    logic [7:0] wr_byte;
    logic [7:0] brownout_control_view;
    logic       pin_reset;

    // Address comparison used by both the read and the write decode.
    function automatic logic addr_hit(input logic [BUS_ADDR_W-1:0] addr,
                                      input logic [3:0]            ofs);
        addr_hit = (addr == ofs);
    endfunction : addr_hit

    // All analog and pin levels pass two flip-flops before any logic sees them.
    // The pin is inverted first so that the all-zero synchroniser reset means idle.
    assign async_raw = {~external_reset_pin_n, brownout_ready_raw,
                        low_power_brownout_detector, brownout_detector};

    level_sync #(
        .WIDTH      (4)
    ) u_sync (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .async_in   (async_raw),
        .idle_value ('0),
        .sync_out   (async_sync)
    );

    assign bod_s    = async_sync[0];
    assign lp_bod_s = async_sync[1];
    assign ready_s  = async_sync[2];
    assign pin_low_s = async_sync[3];

    // Detection enable: mode 01 follows software, 00 is off, other modes run always.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            brownout_detect_enable <= 1'b0;
        end else if (brownout_config_mode == CFG_SOFTWARE) begin
            brownout_detect_enable <= software_brownout_enable_r;
        end else begin
            brownout_detect_enable <= (brownout_config_mode != CFG_ALWAYS_OFF);
        end
    end

    // Generic brown-out reset is the OR of the gated main and low-power detectors.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            brownout_reset <= 1'b0;
        end else begin
            brownout_reset <= (bod_s & brownout_detect_enable)
                            | (lp_bod_s & low_power_brownout_enable);
        end
    end

    // A held-low external reset pin counts only when the pin function is enabled.
    assign pin_reset = external_reset_pin_enable & pin_low_s;

    // Bus handshake: each access waits one cycle, then completes.
    assign bus_req         = avs_read | avs_write;
    assign avs_waitrequest = bus_req & (bus_state_r != BUS_ACK);
    assign wr_take         = avs_write & (bus_state_r == BUS_ACK);
    assign low_lane        = avs_byteenable[0];
    assign wr_byte         = avs_writedata[REG_W-1:0];
    assign hit_brownout_control_wr   = wr_take & low_lane & addr_hit(avs_address, BROWNOUT_CONTROL_OFS);
    assign hit_cause_wr    = wr_take & low_lane & addr_hit(avs_address, RESET_CAUSE_OFS);

    // Handshake state machine.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bus_state_r <= BUS_IDLE;
        end else begin
            case (bus_state_r)
                BUS_IDLE: begin
                    if (bus_req) begin
                        bus_state_r <= BUS_ACK;
                    end
                end
                BUS_ACK: begin
                    bus_state_r <= BUS_IDLE;
                end
                default: begin
                    bus_state_r <= BUS_IDLE;
                end
            endcase
        end
    end

    // Read view of the brown-out control register; unimplemented bits are zero.
    always_comb begin
        brownout_control_view               = '0;
        brownout_control_view[SOFTWARE_BROWNOUT_ENABLE_BIT]   = software_brownout_enable_r;
        brownout_control_view[RESERVED_BIT] = reserved_r;
        brownout_control_view[READY_BIT]    = ready_s & brownout_detect_enable;
    end

    // Read data is captured in the waiting cycle and stands at the completing edge.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= '0;
        end else if (avs_read && bus_state_r == BUS_IDLE) begin
            if (addr_hit(avs_address, BROWNOUT_CONTROL_OFS)) begin
                avs_readdata <= {{(BUS_DATA_W-REG_W){1'b0}}, brownout_control_view};
            end else if (addr_hit(avs_address, RESET_CAUSE_OFS)) begin
                avs_readdata <= {{(BUS_DATA_W-REG_W){1'b0}}, cause_r};
            end else begin
                avs_readdata <= UNMAPPED_READ;
            end
        end
    end

    // Brown-out control: power-on and brown-out load defaults, software writes otherwise.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            software_brownout_enable_r   <= SOFTWARE_BROWNOUT_ENABLE_RESET;
            reserved_r <= RESERVED_RESET;
        end else if (brownout_reset) begin
            software_brownout_enable_r   <= SOFTWARE_BROWNOUT_ENABLE_RESET;
            reserved_r <= RESERVED_RESET;
        end else if (hit_brownout_control_wr) begin
            software_brownout_enable_r   <= wr_byte[SOFTWARE_BROWNOUT_ENABLE_BIT];
            reserved_r <= wr_byte[RESERVED_BIT];
        end
    end

    // Next flag value: software write first, then hardware events override their bit.
    always_comb begin
        cause_nxt = cause_r;
        if (hit_cause_wr) begin
            cause_nxt = wr_byte & CAUSE_WRITE_MASK;
        end
        if (reset_events.stack_overflow) begin
            cause_nxt[STACK_OVERFLOW_FLAG_BIT] = 1'b1;
        end
        if (reset_events.stack_underflow) begin
            cause_nxt[STACK_UNDERFLOW_FLAG_BIT] = 1'b1;
        end
        if (reset_events.watchdog) begin
            cause_nxt[WDT_BIT] = 1'b0;
        end
        if (pin_reset) begin
            cause_nxt[PIN_BIT] = 1'b0;
        end
        if (reset_events.reset_instruction) begin
            cause_nxt[RI_BIT] = 1'b0;
        end
    end

    // Flag register: brown-out reloads all but bit 1; otherwise only the matching cause bit moves and inactive levels come from software.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cause_r <= CAUSE_POR_VALUE;
        end else if (brownout_reset) begin
            cause_r <= (cause_r & CAUSE_BOR_KEEP) | CAUSE_BOR_SET;
        end else begin
            cause_r <= cause_nxt;
        end
    end

endmodule : reset_cause_control

// ===== tb/reset_cause_control_monitor.sv
// Port-level checks for the reset-cause and brown-out control block.
`timescale 1ns/10ps
module reset_cause_control_monitor
    import reset_cause_pkg::*;
(
    // Clock and reset.
    input wire logic                  sys_clk,
    input wire logic                  rstn,
    // Register bus.
    input wire logic [BUS_ADDR_W-1:0] avs_address,
    input wire logic                  avs_read,
    input wire logic                  avs_write,
    input wire logic [BUS_DATA_W-1:0] avs_readdata,
    input wire logic                  avs_waitrequest,
    // Configuration and detectors.
    input wire logic [1:0]            brownout_config_mode,
    input wire logic                  low_power_brownout_enable,
    input wire logic                  brownout_detector,
    input wire logic                  low_power_brownout_detector,
    // Power control outputs.
    input wire logic                  brownout_detect_enable,
    input wire logic                  brownout_reset
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // A read is complete in the cycle its wait state ends.
    logic rd_done;
    assign rd_done = avs_read && !avs_waitrequest;

    // Either detector held active long enough to pass the synchronisers.
    sequence bor_on;
        ((brownout_detector && brownout_detect_enable) ||
         (low_power_brownout_detector && low_power_brownout_enable)) [*5];
    endsequence
    sequence bor_off;
        (!brownout_detector && !low_power_brownout_detector) [*5];
    endsequence

    chk_bor_or_on: assert property (bor_on |-> brownout_reset)
        else $error("Brown-out reset missing.");
    chk_bor_or_off: assert property (bor_off |-> !brownout_reset)
        else $error("Brown-out reset without cause.");
    chk_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("Wait state too long.");
    chk_wait_idle: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
        else $error("Wait while idle.");
    chk_rd_upper: assert property (rd_done |-> avs_readdata[31:8] == 24'h000000)
        else $error("Upper read bits set.");
    chk_ctrl_gap: assert property (rd_done && avs_address == BROWNOUT_CONTROL_OFS |-> avs_readdata[5:1] == 5'h00)
        else $error("Unused control bits set.");
    chk_ready_off: assert property (rd_done && avs_address == BROWNOUT_CONTROL_OFS && $past(brownout_detect_enable) == 1'b0 |-> !avs_readdata[0])
        else $error("Ready bit while disabled.");
    chk_unmapped_zero: assert property (rd_done && avs_address != BROWNOUT_CONTROL_OFS && avs_address != RESET_CAUSE_OFS |-> avs_readdata == UNMAPPED_READ)
        else $error("Unmapped read not zero.");
    chk_mode_off: assert property (brownout_config_mode == CFG_ALWAYS_OFF |=> !brownout_detect_enable)
        else $error("Detection on in off mode.");
    chk_mode_on: assert property (brownout_config_mode[1] |=> brownout_detect_enable)
        else $error("Detection off in on mode.");
endmodule : reset_cause_control_monitor

bind reset_cause_control reset_cause_control_monitor mon (
    .sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .brownout_config_mode(brownout_config_mode),
    .low_power_brownout_enable(low_power_brownout_enable),
    .brownout_detector(brownout_detector),
    .low_power_brownout_detector(low_power_brownout_detector),
    .brownout_detect_enable(brownout_detect_enable), .brownout_reset(brownout_reset));

// ===== tb/reset_cause_control_test.sv
// Self-checking testbench for the reset-cause and brown-out control block.
`timescale 1ns/10ps
module reset_cause_control_test
    import reset_cause_pkg::*;
;
    logic                  sys_clk = 1'b0;
    logic                  rstn, avs_read, avs_write, avs_waitrequest;
    logic [BUS_ADDR_W-1:0] avs_address;
    logic [BUS_DATA_W-1:0] avs_writedata, avs_readdata;
    logic [3:0]            avs_byteenable;
    logic [1:0]            brownout_config_mode;
    logic                  low_power_brownout_enable, external_reset_pin_enable, brownout_detector;
    logic                  low_power_brownout_detector, brownout_ready_raw, external_reset_pin_n;
    reset_event_t          reset_events;
    logic                  brownout_detect_enable, brownout_reset;
    logic [7:0]            rd;
    int                    miscompares = 0;
    int                    compares = 0;

    // Free-running 100 MHz clock.
    always #5 sys_clk = ~sys_clk;

    reset_cause_control dut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .brownout_config_mode(brownout_config_mode),
        .low_power_brownout_enable(low_power_brownout_enable),
        .external_reset_pin_enable(external_reset_pin_enable),
        .brownout_detector(brownout_detector),
        .low_power_brownout_detector(low_power_brownout_detector),
        .brownout_ready_raw(brownout_ready_raw), .external_reset_pin_n(external_reset_pin_n),
        .reset_events(reset_events), .brownout_detect_enable(brownout_detect_enable),
        .brownout_reset(brownout_reset));

    task stop_test;
        $display("Compares %0d, miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One bus cycle, held until waitrequest is seen low; read data lands in rd.
    task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            if (n > 20) begin
                miscompares++;
                stop_test();
            end
            @(posedge sys_clk);
        end
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task rdchk(input string what, input logic [3:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check(what, rd, exp);
    endtask : rdchk

    task s_reset;
        rdchk("control", BROWNOUT_CONTROL_OFS, 8'h81);
        rdchk("cause", RESET_CAUSE_OFS, 8'h1C);
        rdchk("unmapped", 4'h8, 8'h00);
    endtask : s_reset

    task s_control;
        bus(1'b1, BROWNOUT_CONTROL_OFS, 8'hFF);
        rdchk("ctrl all", BROWNOUT_CONTROL_OFS, 8'hC1);
        bus(1'b1, BROWNOUT_CONTROL_OFS, 8'h3E);
        repeat (2) @(posedge sys_clk);
        check("enable sw off", {7'h00, brownout_detect_enable}, 8'h00);
        rdchk("ctrl off", BROWNOUT_CONTROL_OFS, 8'h00);
        brownout_config_mode <= 2'h2;
        repeat (2) @(posedge sys_clk);
        check("enable on", {7'h00, brownout_detect_enable}, 8'h01);
        rdchk("ctrl on", BROWNOUT_CONTROL_OFS, 8'h01);
        brownout_config_mode <= CFG_ALWAYS_OFF;
        bus(1'b1, BROWNOUT_CONTROL_OFS, 8'h80);
        repeat (2) @(posedge sys_clk);
        check("enable off", {7'h00, brownout_detect_enable}, 8'h00);
        rdchk("ctrl mode off", BROWNOUT_CONTROL_OFS, 8'h80);
        brownout_config_mode <= CFG_SOFTWARE;
        repeat (2) @(posedge sys_clk);
        check("enable sw on", {7'h00, brownout_detect_enable}, 8'h01);
    endtask : s_control

    task s_cause;
        bus(1'b1, RESET_CAUSE_OFS, 8'hFF);
        rdchk("forced", RESET_CAUSE_OFS, 8'hDF);
        check("no reset", {7'h00, brownout_reset}, 8'h00);
        bus(1'b1, RESET_CAUSE_OFS, 8'h00);
        repeat (4) @(posedge sys_clk);
        rdchk("cleared", RESET_CAUSE_OFS, 8'h00);
    endtask : s_cause

    task s_events;
        reset_event_t ev [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
        logic [7:0]   ex [4] = '{8'h9F, 8'h5F, 8'h0F, 8'h1B};
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, RESET_CAUSE_OFS, 8'h1F);
            reset_events <= ev[i];
            @(posedge sys_clk);
            reset_events <= '0;
            rdchk("event", RESET_CAUSE_OFS, ex[i]);
        end
        bus(1'b1, RESET_CAUSE_OFS, 8'h1F);
        external_reset_pin_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        external_reset_pin_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rdchk("pin", RESET_CAUSE_OFS, 8'h17);
        reset_events <= 4'h2;
        bus(1'b1, RESET_CAUSE_OFS, 8'h1F);
        reset_events <= '0;
        rdchk("clash", RESET_CAUSE_OFS, 8'h0F);
    endtask : s_events

    task s_brownout;
        bus(1'b1, RESET_CAUSE_OFS, 8'h00);
        bus(1'b1, BROWNOUT_CONTROL_OFS, 8'h00);
        brownout_detector <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check("gated", {7'h00, brownout_reset}, 8'h00);
        brownout_detector <= 1'b0;
        low_power_brownout_detector <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check("low power", {7'h00, brownout_reset}, 8'h01);
        low_power_brownout_detector <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rdchk("bor cause", RESET_CAUSE_OFS, 8'h1C);
        rdchk("bor ctrl", BROWNOUT_CONTROL_OFS, 8'h81);
        bus(1'b1, RESET_CAUSE_OFS, 8'hDF);
        brownout_detector <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check("main", {7'h00, brownout_reset}, 8'h01);
        brownout_detector <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rdchk("bor keep", RESET_CAUSE_OFS, 8'h1E);
    endtask : s_brownout

    // Reset, then the scenarios in turn.
    initial begin
        {rstn, avs_read, avs_write, avs_address, avs_writedata} = '0;
        {brownout_detector, low_power_brownout_detector, reset_events} = '0;
        {avs_byteenable, brownout_config_mode} = {4'hF, CFG_SOFTWARE};
        {low_power_brownout_enable, external_reset_pin_enable} = 2'h3;
        {brownout_ready_raw, external_reset_pin_n} = 2'h3;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        s_reset();
        s_control();
        s_cause();
        s_events();
        s_brownout();
        stop_test();
    end
endmodule : reset_cause_control_test
